// file: common/csp_defines.vh
// Operation
// - holding priority in tuning position shows offset digits, 0.6 after power-on
// - encoder steps move the offset up or down by 100 kHz
// - store button during offset adjustment keeps the new offset until reset
// - stored channels are written only from the first tuning register
// - unwritten stored channels hold and receive the power-on preset frequency
// - one store press on a stored channel copies the first tuning register
// - a stored channel becomes operating; tuning position restores its frequency
// - channel scan cycles channels one to five, then first, second register
// - each scan button press toggles scanning, with or without squelch events
// - a setting picks stop on busy channel or stop on empty channel
// - range scan runs down from channel two edge toward channel one edge
// - at the lower edge the scan jumps to the upper edge, endlessly
// - with squelch not engaged the scan never stops on a signal
// - a manual stop without retuning resumes from the stop frequency
// - retuned while stopped restarts there, below lower edge from upper edge
// - retuned above the upper edge starts there and wraps to upper edge
// - full-band scan covers 144.000 to 145.995 MHz downward from the register
// - decimal point blinks at scan step rate while scan is active or paused
// - busy stop without timer resumes when the signal disappears
// - empty stop without timer resumes when a signal appears
// - with the stop timer on, an auto pause ends after the set interval
// - priority on lights indicator, alternates register 5 s and channel 1 s
// - transmit in priority uses the register frequency; cycle continues after
// - priority off darkens indicator and operates on the priority channel
// - duplex transmits receive minus offset; reverse swaps the two
// - steps are 5 kHz on the first register and 25 kHz on the second
`ifndef CSP_DEFINES_VH
`define CSP_DEFINES_VH

// frequencies are 5 kHz step indices counted up from 144.000 MHz
`define CSP_FREQ_MAX 9'h18F
`define CSP_BAND_SIZE 10'h190
`define CSP_FREQ_PRESET 9'h0C8
`define CSP_STEP_FIRST 9'h001
`define CSP_STEP_SECOND 9'h005

// offset counts 100 kHz units
`define CSP_OFFSET_PRESET 5'h06
`define CSP_OFFSET_MAX 5'h13

// apb register byte offsets
`define CSP_REG_CTRL 8'h00
`define CSP_REG_SCAN_PERIOD 8'h04
`define CSP_REG_STOP_TIME 8'h08
`define CSP_REG_STATUS 8'h0C
`define CSP_REG_FREQ 8'h10

// control register fields
`define CSP_CTRL_SEL_HI 2
`define CSP_CTRL_SEL_LO 0
`define CSP_CTRL_USE_SECOND 3
`define CSP_CTRL_MODE_HI 5
`define CSP_CTRL_MODE_LO 4
`define CSP_CTRL_STOP_EMPTY 6
`define CSP_CTRL_TIMER_EN 7
`define CSP_CTRL_SPLIT 8
`define CSP_CTRL_SWAPPED 9
`define CSP_CTRL_WIDTH 10

`define CSP_MODE_CHANNEL 2'h0
`define CSP_MODE_RANGE 2'h1
`define CSP_MODE_FULL 2'h2

// timing
`define CSP_CLK_KHZ 40000
`define CSP_ONE_SECOND_MS 1000
`define CSP_SCAN_TICK_MS 100
`define CSP_PRIO_TUNING_S 5'h05
`define CSP_PRIO_CHANNEL_S 5'h01
`define CSP_STOP_TIME_MIN_S 5'h05
`define CSP_STOP_TIME_MAX_S 5'h19
`define CSP_STOP_TIME_RESET 5'h05

`endif

// file: verilog/csp_tick.v
`timescale 1ns/1ps
module csp_tick (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_restart,
  input wire [31:0] i_period,
  output reg o_tick
);
  reg [31:0] count;
  wire [31:0] last = (i_period == 32'h0000_0000) ? 32'h0000_0000 :
                     i_period - 32'h0000_0001;

  always @(posedge i_clk) begin
    if (!i_reset_n || i_restart) begin
      count <= 32'h0000_0000;
      o_tick <= 1'b0;
    end else if (count >= last) begin
      count <= 32'h0000_0000;
      o_tick <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      o_tick <= 1'b0;
    end
  end
endmodule

// file: verilog/csp_scan_ctrl.v
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "csp_defines.vh"
module csp_scan_ctrl #(
  parameter ONE_SECOND_CYCLES = `CSP_ONE_SECOND_MS * `CSP_CLK_KHZ,
  parameter SCAN_TICK_CYCLES = `CSP_SCAN_TICK_MS * `CSP_CLK_KHZ
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output reg o_pslverr,
  input wire i_enc_cw,
  input wire i_enc_ccw,
  input wire i_store_button,
  input wire i_priority_button,
  input wire i_scan_button,
  input wire i_squelch_open,
  input wire i_squelch_engaged,
  input wire i_ptt,
  output reg [8:0] o_synth_freq,
  output reg [8:0] o_display_freq,
  output reg o_tx_active,
  output reg o_offset_display,
  output reg [7:0] o_offset_digits,
  output reg o_decimal_point,
  output reg o_priority_led
);
  ////////////////////////////////////////////////////////////////////////////
  function [8:0] f_add;
    input [8:0] a;
    input [8:0] b;
    reg [9:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      if (s >= `CSP_BAND_SIZE) begin
        s = s - `CSP_BAND_SIZE;
      end
      f_add = s[8:0];
    end
  endfunction

  function [8:0] f_sub;
    input [8:0] a;
    input [8:0] b;
    reg [9:0] s;
    begin
      if (a >= b) begin
        s = {1'b0, a} - {1'b0, b};
      end else begin
        s = {1'b0, a} + `CSP_BAND_SIZE - {1'b0, b};
      end
      f_sub = s[8:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // panel pins are asynchronous: two flops, then edge detection
  reg [7:0] sync1;
  reg [7:0] sync2;
  reg [7:0] prev;
  wire [7:0] pins = {i_ptt, i_squelch_engaged, i_squelch_open, i_scan_button,
                     i_priority_button, i_store_button, i_enc_ccw, i_enc_cw};
  wire [7:0] rise = sync2 & ~prev;

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      prev <= 8'h00;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  wire cw = rise[0];
  wire ccw = rise[1];
  wire store_press = rise[2];
  wire prio_press = rise[3];
  wire prio_held = sync2[3];
  wire scan_press = rise[4];
  wire sq_open = sync2[5];
  wire sq_engaged = sync2[6];
  wire ptt = sync2[7];

  ////////////////////////////////////////////////////////////////////////////
  reg [`CSP_CTRL_WIDTH-1:0] ctrl;
  reg [31:0] scan_period;
  reg [4:0] stop_time;

  wire [2:0] sel = ctrl[`CSP_CTRL_SEL_HI:`CSP_CTRL_SEL_LO];
  wire use_second = ctrl[`CSP_CTRL_USE_SECOND];
  wire [1:0] mode = ctrl[`CSP_CTRL_MODE_HI:`CSP_CTRL_MODE_LO];
  wire stop_empty = ctrl[`CSP_CTRL_STOP_EMPTY];
  wire timer_en = ctrl[`CSP_CTRL_TIMER_EN];
  wire split = ctrl[`CSP_CTRL_SPLIT];
  wire swapped = ctrl[`CSP_CTRL_SWAPPED];
  // selector codes 6 and 7 fall back to the tuning position
  wire chan_sel = (sel >= 3'h1) && (sel <= 3'h5);
  wire [2:0] chan_idx = sel - 3'h1;

  reg [8:0] vfo_a;
  reg [8:0] vfo_b;
  reg [8:0] chan [0:4];
  reg [4:0] offset;
  reg [4:0] offset_edit;
  reg scan_on;
  reg scan_paused;
  reg skip_check;
  reg [4:0] pause_secs;
  reg [2:0] mem_idx;
  reg dp_blink;
  reg prio_on;
  reg prio_phase;
  reg [4:0] prio_secs;
  reg [2:0] prio_ch;
  reg stay_prio;
  reg [2:0] sel_prev;
  integer i;

  wire scan_tick;
  wire sec_tick;

  csp_tick u_scan_tick (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_restart(1'b0),
    .i_period(scan_period),
    .o_tick(scan_tick)
  );

  // restarted on priority entry so the first tuning slot is a full 5 s
  csp_tick u_sec_tick (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_restart(prio_press && chan_sel && !prio_on),
    .i_period(ONE_SECOND_CYCLES),
    .o_tick(sec_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  wire [8:0] cur_vfo = use_second ? vfo_b : vfo_a;
  wire [8:0] step = use_second ? `CSP_STEP_SECOND : `CSP_STEP_FIRST;
  wire range_mode = (mode == `CSP_MODE_RANGE);
  wire [8:0] low_edge = range_mode ? chan[0] : 9'h000;
  wire [8:0] high_edge = range_mode ? chan[1] : `CSP_FREQ_MAX;
  wire offset_view = prio_held && !chan_sel;
  wire stop_cond = sq_engaged && (stop_empty ? !sq_open : sq_open);
  wire [4:0] stop_lim = (stop_time < `CSP_STOP_TIME_MIN_S) ?
                        `CSP_STOP_TIME_MIN_S :
                        (stop_time > `CSP_STOP_TIME_MAX_S) ?
                        `CSP_STOP_TIME_MAX_S : stop_time;
  wire [4:0] prio_lim = prio_phase ? `CSP_PRIO_CHANNEL_S : `CSP_PRIO_TUNING_S;

  reg [8:0] scan_next;
  reg [8:0] tune_next;
  always @* begin
    // wrap to the upper edge once a further step would pass the lower one
    if (cur_vfo <= low_edge || cur_vfo - low_edge < step) begin
      scan_next = high_edge;
    end else begin
      scan_next = cur_vfo - step;
    end
    if (cw) begin
      tune_next = f_add(cur_vfo, step);
    end else begin
      tune_next = f_sub(cur_vfo, step);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      vfo_a <= `CSP_FREQ_PRESET;
      vfo_b <= `CSP_FREQ_PRESET;
      for (i = 0; i < 5; i = i + 1) begin
        chan[i] <= `CSP_FREQ_PRESET;
      end
      offset <= `CSP_OFFSET_PRESET;
      offset_edit <= `CSP_OFFSET_PRESET;
      scan_on <= 1'b0;
      scan_paused <= 1'b0;
      skip_check <= 1'b0;
      pause_secs <= 5'h00;
      mem_idx <= 3'h0;
      dp_blink <= 1'b0;
      prio_on <= 1'b0;
      prio_phase <= 1'b0;
      prio_secs <= 5'h00;
      prio_ch <= 3'h0;
      stay_prio <= 1'b0;
      sel_prev <= 3'h0;
    end else begin
      sel_prev <= sel;
      if (sel != sel_prev) begin
        stay_prio <= 1'b0;
      end
      // offset adjustment while the priority button is held
      if (prio_press && !chan_sel) begin
        offset_edit <= offset;
      end else if (offset_view && cw && offset_edit < `CSP_OFFSET_MAX) begin
        offset_edit <= offset_edit + 5'h01;
      end else if (offset_view && ccw && offset_edit != 5'h00) begin
        offset_edit <= offset_edit - 5'h01;
      end
      if (offset_view && store_press) begin
        offset <= offset_edit;
      end
      // stored channels take the first register only
      if (store_press && chan_sel) begin
        chan[chan_idx] <= vfo_a;
      end
      // tuning-register updates: scan step, start adjust, knob, transfer
      if (scan_on && !scan_paused && scan_tick && !(stop_cond && !skip_check)
          && mode != `CSP_MODE_CHANNEL) begin
        if (use_second) begin
          vfo_b <= scan_next;
        end else begin
          vfo_a <= scan_next;
        end
      end else if (scan_press && !scan_on && range_mode
                   && cur_vfo < low_edge) begin
        if (use_second) begin
          vfo_b <= high_edge;
        end else begin
          vfo_a <= high_edge;
        end
      end else if (!scan_on && !offset_view && !chan_sel && (cw || ccw)) begin
        if (use_second) begin
          vfo_b <= tune_next;
        end else begin
          vfo_a <= tune_next;
        end
      end else if (store_press && !offset_view && !chan_sel) begin
        if (use_second) begin
          vfo_b <= vfo_a;
        end else begin
          vfo_a <= vfo_b;
        end
      end
      // scan run, manual toggle and automatic pause
      if (scan_press) begin
        scan_on <= !scan_on;
        scan_paused <= 1'b0;
        skip_check <= 1'b0;
      end else if (scan_on && !scan_paused && scan_tick) begin
        if (stop_cond && !skip_check) begin
          scan_paused <= 1'b1;
          pause_secs <= 5'h00;
        end else begin
          skip_check <= 1'b0;
          if (mode == `CSP_MODE_CHANNEL) begin
            mem_idx <= (mem_idx == 3'h6) ? 3'h0 : mem_idx + 3'h1;
          end
        end
      end else if (scan_on && scan_paused) begin
        if (timer_en) begin
          if (sec_tick) begin
            if (pause_secs + 5'h01 >= stop_lim) begin
              scan_paused <= 1'b0;
              skip_check <= 1'b1;
            end else begin
              pause_secs <= pause_secs + 5'h01;
            end
          end
        end else if (!stop_cond) begin
          scan_paused <= 1'b0;
        end
      end
      if (!scan_on) begin
        dp_blink <= 1'b0;
      end else if (scan_tick) begin
        dp_blink <= !dp_blink;
      end
      // priority alternation
      if (prio_press && chan_sel) begin
        prio_on <= !prio_on;
        prio_phase <= 1'b0;
        prio_secs <= 5'h00;
        prio_ch <= chan_idx;
        stay_prio <= prio_on;
      end else if (prio_on && sec_tick) begin
        if (prio_secs + 5'h01 >= prio_lim) begin
          prio_phase <= !prio_phase;
          prio_secs <= 5'h00;
        end else begin
          prio_secs <= prio_secs + 5'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  reg [8:0] op_freq;
  reg [8:0] tx_base;
  reg [8:0] rx_freq;
  reg [8:0] tx_freq;
  wire [8:0] off_units = {offset, 4'h0} + {2'b00, offset, 2'b00};

  always @* begin
    if (scan_on && mode == `CSP_MODE_CHANNEL) begin
      if (mem_idx < 3'h5) begin
        op_freq = chan[mem_idx];
      end else if (mem_idx == 3'h5) begin
        op_freq = vfo_a;
      end else begin
        op_freq = vfo_b;
      end
    end else if (prio_on) begin
      op_freq = prio_phase ? chan[prio_ch] : cur_vfo;
    end else if (stay_prio) begin
      op_freq = chan[prio_ch];
    end else if (chan_sel) begin
      op_freq = chan[chan_idx];
    end else begin
      op_freq = cur_vfo;
    end
    // while priority is on, transmit uses the tuning register, not the priority channel
    tx_base = prio_on ? cur_vfo : op_freq;
    if (!split) begin
      rx_freq = op_freq;
      tx_freq = tx_base;
    end else if (!swapped) begin
      rx_freq = op_freq;
      tx_freq = f_sub(tx_base, off_units);
    end else begin
      rx_freq = f_sub(op_freq, off_units);
      tx_freq = tx_base;
    end
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_synth_freq <= `CSP_FREQ_PRESET;
      o_display_freq <= `CSP_FREQ_PRESET;
      o_tx_active <= 1'b0;
      o_offset_display <= 1'b0;
      o_offset_digits <= 8'h06;
      o_decimal_point <= 1'b1;
      o_priority_led <= 1'b0;
    end else begin
      o_synth_freq <= ptt ? tx_freq : rx_freq;
      o_display_freq <= ptt ? tx_freq : rx_freq;
      o_tx_active <= ptt;
      o_offset_display <= offset_view;
      if (offset_edit >= 5'h0A) begin
        o_offset_digits <= {4'h1, offset_edit[3:0] - 4'hA};
      end else begin
        o_offset_digits <= {4'h0, offset_edit[3:0]};
      end
      o_decimal_point <= scan_on ? dp_blink : 1'b1;
      o_priority_led <= prio_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, read data captured in the setup cycle
  assign o_pready = 1'b1;
  wire apb_write = i_psel && i_penable && i_pwrite;

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      ctrl <= {`CSP_CTRL_WIDTH{1'b0}};
      scan_period <= SCAN_TICK_CYCLES;
      stop_time <= `CSP_STOP_TIME_RESET;
    end else if (apb_write) begin
      case (i_paddr)
        `CSP_REG_CTRL: begin
          ctrl <= i_pwdata[`CSP_CTRL_WIDTH-1:0];
        end
        `CSP_REG_SCAN_PERIOD: begin
          scan_period <= i_pwdata;
        end
        `CSP_REG_STOP_TIME: begin
          stop_time <= i_pwdata[4:0];
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_psel && !i_penable) begin
      o_pslverr <= 1'b0;
      case (i_paddr)
        `CSP_REG_CTRL: begin
          o_prdata <= {22'h00_0000, ctrl};
        end
        `CSP_REG_SCAN_PERIOD: begin
          o_prdata <= scan_period;
        end
        `CSP_REG_STOP_TIME: begin
          o_prdata <= {27'h000_0000, stop_time};
        end
        `CSP_REG_STATUS: begin
          o_prdata <= {14'h0000, mem_idx, prio_phase, offset_edit, offset,
                       offset_view, prio_on, scan_paused, scan_on};
        end
        `CSP_REG_FREQ: begin
          o_prdata <= {7'h00, tx_freq, 7'h00, rx_freq};
        end
        default: begin
          o_prdata <= 32'h0000_0000;
          o_pslverr <= 1'b1;
        end
      endcase
    end
  end
endmodule

// file: verif/csp_panel_model.sv
`timescale 1ns/1ps
module csp_panel_model (
  input wire logic i_clk,
  input wire logic i_engaged,
  input wire logic i_carrier,
  input wire logic [8:0] i_freq,
  input wire logic [8:0] i_busy_freq,
  output logic o_open
);
  // an unsquelched receiver passes noise, which reads as open
  always_ff @(posedge i_clk) begin
    o_open <= !i_engaged | (i_carrier & (i_freq == i_busy_freq));
  end
endmodule

// file: verif/csp_scan_ctrl_properties.sv
`timescale 1ns/1ps
module csp_scan_ctrl_properties (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_psel,
  input wire i_penable,
  input wire [7:0] i_paddr,
  input wire i_priority_button,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire [8:0] o_synth_freq,
  input wire [8:0] o_display_freq,
  input wire [7:0] o_offset_digits,
  input wire o_priority_led
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_access;
    i_psel && i_penable;
  endsequence
  sequence s_mapped;
    s_access ##0 (i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
  endsequence
  chk_pready_high:
    assert property (o_pready) else $error("pready low");
  chk_err_unmapped:
    assert property (s_access ##0 !(i_paddr inside {8'h00, 8'h04, 8'h08,
      8'h0C, 8'h10}) |-> o_pslverr && o_prdata == 32'h0)
      else $error("unmapped access not refused");
  chk_err_mapped:
    assert property (s_mapped |-> !o_pslverr) else $error("mapped error");
  chk_preset_out:
    assert property ($rose(i_reset_n) |-> o_synth_freq == 9'h0C8 &&
      o_offset_digits == 8'h06 && !o_priority_led)
      else $error("power-on preset wrong");
  chk_disp_same:
    assert property (o_display_freq == o_synth_freq)
      else $error("display differs from synth");
  chk_freq_band:
    assert property (o_synth_freq <= 9'h18F) else $error("out of band");
  chk_offset_bcd:
    assert property (o_offset_digits[7:4] <= 4'h1 &&
      o_offset_digits[3:0] <= 4'h9) else $error("offset digits bad");
  chk_led_cause:
    assert property ($rose(o_priority_led) |-> $past(i_priority_button, 4)
      || $past(i_priority_button, 5) || $past(i_priority_button, 6))
      else $error("priority led without press");
endmodule
bind csp_scan_ctrl csp_scan_ctrl_properties u_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_paddr(i_paddr),
  .i_priority_button(i_priority_button), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_synth_freq(o_synth_freq),
  .o_display_freq(o_display_freq), .o_offset_digits(o_offset_digits),
  .o_priority_led(o_priority_led)
);

// file: verif/tb_csp_scan_ctrl.sv
`timescale 1ns/1ps
`include "csp_defines.vh"
module tb_csp_scan_ctrl;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, er;
  logic eng = 0, ptt = 0, car = 0, sqo, pd;
  logic [4:0] btn = 5'h00;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [8:0] busy = 9'h000, a0, fa, pv, fq, ch[0:6];
  wire [31:0] prdata;
  wire pready, pslverr, txa, offv, dp, led;
  wire [8:0] synth;
  wire [7:0] digs;
  int err_count = 0, tests_run = 0, seed = 99, cyc = 0, n, gap;
  csp_scan_ctrl #(.ONE_SECOND_CYCLES(20), .SCAN_TICK_CYCLES(8)) dut (
    .i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_enc_cw(btn[0]),
    .i_enc_ccw(btn[1]), .i_store_button(btn[2]), .i_scan_button(btn[3]),
    .i_priority_button(btn[4]), .i_squelch_open(sqo),
    .i_squelch_engaged(eng), .i_ptt(ptt), .o_synth_freq(synth),
    .o_display_freq(), .o_tx_active(txa), .o_offset_display(offv),
    .o_offset_digits(digs), .o_decimal_point(dp), .o_priority_led(led));
  csp_panel_model u_sq (.i_clk(clk), .i_engaged(eng), .i_carrier(car),
    .i_freq(synth), .i_busy_freq(busy), .o_open(sqo));
  ////////////////////////////////////////////////////////////////////////
  initial forever #12.5 clk = ~clk;
  task summarize;
    $display("errors %0d comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // a hung wait would otherwise stall the whole run silently
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  task chk(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t exp %h got %h", $time, e, g);
    end
  endtask
  task tk(input int k);
    repeat (k) @(posedge clk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  task ctl(input logic [31:0] v);
    apb(1, `CSP_REG_CTRL, v);
    tk(3);
  endtask
  // pins go through synchronisers, so each level is held well past 3 clocks
  task pin(input int k);
    @(posedge clk);
    btn[k] <= 1'b1;
    tk(5);
    btn[3:0] <= 4'h0;
    if (k == 4) btn[4] <= 1'b0;
    tk(5);
  endtask
  task chg;
    pv = synth;
    gap = 0;
    do begin
      @(posedge clk);
      gap++;
    end while (synth === pv && gap < 300);
    fq = synth;
  endtask
  function logic [8:0] nm(input logic [8:0] f);
    nm = ch[0];
    for (int j = 0; j < 7; j++) if (ch[j] === f) nm = ch[(j + 1) % 7];
  endfunction
  function logic [8:0] dn(input logic [8:0] f);
    dn = (f <= ch[0]) ? ch[1] : f - 9'h001;
  endfunction
  function logic [8:0] sub(input logic [8:0] f, input int o);
    sub = (f + 400 - o) % 400;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tk(3);
    rst_n <= 1;
    tk(2);
    chk(9'h0C8, synth);
    chk(8'h06, digs);
    chk(1, dp);
    apb(0, `CSP_REG_SCAN_PERIOD, 0);
    chk(8, rd);
    apb(0, `CSP_REG_STOP_TIME, 0);
    chk(5, rd);
    apb(0, 8'h24, 0);
    chk(1, er);
    n = 6 + ({$random(seed)} % 4);
    repeat (n) pin(0);
    a0 = 9'h0C8 + n;
    chk(a0, synth);
    ctl(32'h8);
    pin(0);
    chk(9'h0CD, synth);
    ctl(0);
    chk(a0, synth);
    ctl(1);
    chk(9'h0C8, synth);
    // channel two is written with the second register picked
    for (int k = 1; k <= 5; k++) begin
      ctl(0);
      pin(0);
      ctl(k | ((k == 2) ? 8 : 0));
      pin(2);
      ch[k - 1] = a0 + k;
      chk(ch[k - 1], synth);
    end
    ctl(0);
    pin(0);
    ch[5] = a0 + 6;
    ch[6] = 9'h0CD;
    apb(1, `CSP_REG_SCAN_PERIOD, 10);
    pin(3);
    chg;
    for (int i = 0; i < 7; i++) begin
      pd = dp;
      chg;
      chk(10, gap);
      chk(nm(pv), fq);
      chk(!pd, dp);
    end
    pin(3);
    fq = synth;
    tk(30);
    chk(fq, synth);
    chk(1, dp);
    eng <= 1;
    busy <= ch[0];
    car <= 1;
    ctl(32'h10);
    pin(3);
    for (int i = 0; i < 8 && fq !== ch[0]; i++) begin
      chg;
      if (i > 0) chk(dn(pv), fq);
    end
    tk(40);
    chk(ch[0], synth);
    car <= 0;
    chg;
    chk(ch[1], fq);
    ctl(32'h90);
    car <= 1;
    fq = synth;
    for (int i = 0; i < 4 && fq !== ch[0]; i++) chg;
    chg;
    chk(ch[1], fq);
    chk(1, gap >= 75 && gap <= 140);
    pin(3);
    car <= 0;
    eng <= 0;
    ctl(32'h10);
    n = synth - ch[0] + 1;
    repeat (n) pin(1);
    @(posedge clk);
    btn[3] <= 1'b1;
    chg;
    chk(ch[1], fq);
    btn[3] <= 1'b0;
    tk(5);
    pin(3);
    ctl(0);
    fa = synth;
    btn[4] <= 1'b1;
    tk(8);
    chk(1, offv);
    chk(8'h06, digs);
    repeat (5) pin(0);
    pin(1);
    chk(8'h10, digs);
    pin(2);
    btn[4] <= 1'b0;
    tk(8);
    chk(0, offv);
    chk(fa, synth);
    ctl(32'h100);
    apb(0, `CSP_REG_FREQ, 0);
    chk({7'h0, sub(fa, 200), 7'h0, fa}, rd);
    ctl(32'h300);
    apb(0, `CSP_REG_FREQ, 0);
    chk({7'h0, fa, 7'h0, sub(fa, 200)}, rd);
    ptt <= 1;
    tk(8);
    chk(1, txa);
    chk(fa, synth);
    ptt <= 0;
    ctl(3);
    pin(4);
    chk(1, led);
    fq = synth;
    for (int i = 0; i < 3 && fq !== ch[2]; i++) chg;
    chg;
    chk(fa, fq);
    chk(1, gap >= 15 && gap <= 25);
    chg;
    chk(ch[2], fq);
    chk(1, gap >= 90 && gap <= 110);
    pin(4);
    chk(0, led);
    chk(ch[2], synth);
    summarize();
  end
endmodule
